// *** verilog/gdc_config_regs.sv ***
/*
  Sense amplifier and gate drive configuration registers with calibration
  triggers and decoded settings. Assumes the serial interface delivers a
  decoded one-cycle write strobe and index, and reads data
  registered here on a read strobe.
*/
`timescale 1ns/1ps
module gdc_config_regs #(
  parameter int CAL_CYCLES = gdc_pkg::CAL_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sleepEnter,
  // Register access port
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [3:0]  regIndex,
  input  wire logic [11:0] regWdata,
  output logic      [11:0] regRdata,
  output logic             regHit,
  // Calibration setting
  input  wire logic        calInputConnect,
  // Sense settings
  output logic      [9:0]  overcurrentThreshMv,
  output logic      [5:0]  senseGain,
  output logic             emfSenseEnable,
  output logic             ampCForEmf,
  output logic      [3:0]  emfGainQuarters,
  output logic             commonPinSel,
  // Calibration controls
  output logic             calRunA,
  output logic             calRunB,
  output logic             calRunC,
  output logic             calRunEmf,
  output logic             calShortInputs,
  // Drive settings
  output logic      [12:0] gateTransitionNs,
  output logic      [10:0] hsSourceMa,
  output logic      [11:0] hsSinkMa,
  output logic      [10:0] lsSourceMa,
  output logic      [11:0] lsSinkMa
);
  import gdc_pkg::*;
  if (CAL_CYCLES < 1) begin : g_bad_cycles
    $error("CAL_CYCLES must be at least one");
  end

  logic [11:0] sense_q, sense_d;
  logic [11:0] drive_q, drive_d;
  logic [11:0] rdata_d;
  logic        hit_d;
  logic        calEmf_q, calEmf_d;
  logic [2:0]  busy, start;
  logic        wrSense, wrDrive, clrRegs;

  always_comb begin
    clrRegs = sleepEnter;
    wrSense = regWrite && regIndex == SENSE_IDX;
    wrDrive = regWrite && regIndex == DRIVE_IDX;
    // Trigger starts only on a written one while idle; zero ignored
    start[2] = wrSense && regWdata[CAL_A_BIT] && !busy[2];
    start[1] = wrSense && regWdata[CAL_B_BIT] && !busy[1];
    start[0] = wrSense && regWdata[CAL_C_BIT] && !busy[0];
  end

  // Calibration sequencers, A, B, C-or-emf
  for (genvar i = 0; i < 3; i++) begin : g_cal
    gdc_cal_seq #(
      .CYCLES (CAL_CYCLES)
    ) u_cal (
      .clk     (clk),
      .sys_rst (sys_rst),
      .start   (start[i]),
      .abort   (clrRegs),
      .busy    (busy[i]),
      .done    ()
    );
  end

  always_comb begin
    sense_d  = sense_q;
    drive_d  = drive_q;
    calEmf_d = calEmf_q;
    if (clrRegs) begin
      sense_d  = SENSE_RST;
      drive_d  = DRIVE_RST;
      calEmf_d = 1'b0;
    end else begin
      if (wrSense) sense_d = (regWdata & SENSE_WR_MASK) | (sense_q & ~SENSE_WR_MASK);
      if (wrDrive) drive_d = (regWdata & DRIVE_WR_MASK) | (drive_q & ~DRIVE_WR_MASK);
      // Emf enable at the start decides which amplifier is calibrated
      if (start[0]) calEmf_d = wrSense ? regWdata[EMF_EN_BIT] : sense_q[EMF_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sense_q  <= SENSE_RST;
      drive_q  <= DRIVE_RST;
      calEmf_q <= 1'b0;
    end else begin
      sense_q  <= sense_d;
      drive_q  <= drive_d;
      calEmf_q <= calEmf_d;
    end
  end

  // Read back; trigger bits show running calibrations
  always_comb begin
    rdata_d = regRdata;
    hit_d   = 1'b0;
    if (regRead) begin
      hit_d = (regIndex == SENSE_IDX) || (regIndex == DRIVE_IDX);
      unique case (regIndex)
        SENSE_IDX: begin
          rdata_d = sense_q & SENSE_WR_MASK;
          rdata_d[CAL_A_BIT] = busy[2] | start[2];
          rdata_d[CAL_B_BIT] = busy[1] | start[1];
          rdata_d[CAL_C_BIT] = busy[0] | start[0];
        end
        DRIVE_IDX: rdata_d = drive_q & DRIVE_WR_MASK;
        default:   rdata_d = 12'h000;
      endcase
    end
  end

  // Decoded sense settings and drive transition time
  logic [9:0] thMv_d;
  logic [5:0] gain_d;
  logic [3:0] emfG_d;
  logic [12:0] gtNs_d;
  always_comb begin
    thMv_d = 10'd50;
    unique case (sense_q[OC_TH_LSB +: 3])
      3'h0: thMv_d = 10'd50;
      3'h1: thMv_d = 10'd100;
      3'h2: thMv_d = 10'd150;
      3'h3: thMv_d = 10'd200;
      3'h4: thMv_d = 10'd250;
      3'h5: thMv_d = 10'd500;
      3'h6: thMv_d = 10'd750;
      3'h7: thMv_d = 10'd1000;
    endcase
    gain_d = 6'(6'd5 << sense_q[CS_GAIN_LSB +: 2]);
    emfG_d = 4'(4'd1 << sense_q[EMF_GAIN_LSB +: 2]);
    gtNs_d = 13'(13'd500 << drive_q[GT_TIME_LSB +: 2]);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdata            <= 12'h000;
      regHit              <= 1'b0;
      overcurrentThreshMv <= 10'h000;
      senseGain           <= 6'h00;
      emfSenseEnable      <= 1'b0;
      ampCForEmf          <= 1'b0;
      emfGainQuarters     <= 4'h0;
      commonPinSel        <= 1'b0;
      calRunA             <= 1'b0;
      calRunB             <= 1'b0;
      calRunC             <= 1'b0;
      calRunEmf           <= 1'b0;
      calShortInputs      <= 1'b0;
      gateTransitionNs    <= 13'h0000;
    end else begin
      regRdata            <= rdata_d;
      regHit              <= hit_d;
      overcurrentThreshMv <= thMv_d;
      senseGain           <= gain_d;
      emfSenseEnable      <= sense_q[EMF_EN_BIT];
      ampCForEmf          <= sense_q[EMF_EN_BIT];
      emfGainQuarters     <= emfG_d;
      commonPinSel        <= sense_q[COMMON_SEL_BIT];
      calRunA             <= busy[2];
      calRunB             <= busy[1];
      calRunC             <= busy[0] && !calEmf_q;
      calRunEmf           <= busy[0] && calEmf_q;
      calShortInputs      <= !calInputConnect && (busy != 3'h0);
      gateTransitionNs    <= gtNs_d;
    end
  end

  // Drive current decode, sink twice source
  gdc_src_decode u_hs (
    .clk     (clk),
    .sys_rst (sys_rst),
    .code    (drive_q[HS_SRC_LSB +: 4]),
    .srcMa   (hsSourceMa),
    .sinkMa  (hsSinkMa)
  );

  gdc_src_decode u_ls (
    .clk     (clk),
    .sys_rst (sys_rst),
    .code    (drive_q[LS_SRC_LSB +: 4]),
    .srcMa   (lsSourceMa),
    .sinkMa  (lsSinkMa)
  );

endmodule : gdc_config_regs

// *** verilog/gdc_pkg.sv ***
/*
  Package for the gate driver sense and drive configuration bank: register
  indices, field positions, reset values, decode codes and calibration timing.
  Assumes a register access port already decoded from the serial interface.
*/
// Behaviour
// - Bits 11:9 pick overcurrent threshold, 50-1000 mV
// - Bits 8:7 pick sense gain 5-40
// - Bit 6 starts amp A calibration, self-clears
// - Bit 5 starts amp B calibration, self-clears
// - Bit 4 calibrates amp C when emf off
// - Bit 4 calibrates emf amps when emf on
// - Bit 3 enables emf sensing, repurposes C
// - Bits 2:1 pick emf gain 0.25-2
// - Bit 0 picks virtual or pin common
// - Drive bits 11:10 pick transition time
// - Drive bits 9:6 pick high-side source current
// - Drive bits 5:2 pick low-side source current
// - Sink current is twice source current
// - Documented defaults load at reset
// - Sleep or shutdown restores register defaults
// - Calibration input connect shorts or keeps shunt
package gdc_pkg;
  localparam int          REG_W           = 12;
  localparam logic [3:0]  SENSE_IDX       = 4'h4;
  localparam logic [3:0]  DRIVE_IDX       = 4'h5;
  // Sense register fields
  localparam int          OC_TH_LSB       = 9;
  localparam int          CS_GAIN_LSB     = 7;
  localparam int          CAL_A_BIT       = 6;
  localparam int          CAL_B_BIT       = 5;
  localparam int          CAL_C_BIT       = 4;
  localparam int          EMF_EN_BIT      = 3;
  localparam int          EMF_GAIN_LSB    = 1;
  localparam int          COMMON_SEL_BIT  = 0;
  // Drive register fields
  localparam int          GT_TIME_LSB     = 10;
  localparam int          HS_SRC_LSB      = 6;
  localparam int          LS_SRC_LSB      = 2;
  // Reset values
  localparam logic [11:0] SENSE_RST       = 12'h0_B02;
  localparam logic [11:0] DRIVE_RST       = 12'h0_7FC;
  localparam logic [11:0] SENSE_WR_MASK   = 12'h0_F8F;
  localparam logic [11:0] DRIVE_WR_MASK   = 12'h0_FFC;
  // Calibration time
  localparam int          CAL_TIME_US     = 100;
  localparam int          CLK_MHZ         = 250;
  localparam int          CAL_CYCLES      = CAL_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {
    GDC_IDLE = 2'b00,
    GDC_RUN  = 2'b01,
    GDC_DONE = 2'b11
  } gdc_cal_t;
  function automatic logic [10:0] gdc_src_ma(input logic [3:0] code);
    logic [10:0] v;
    v = 11'h000;
    unique case (code)
      4'h0: v = 11'd50;
      4'h1: v = 11'd70;
      4'h2: v = 11'd120;
      4'h3: v = 11'd160;
      4'h4: v = 11'd200;
      4'h5: v = 11'd220;
      4'h6: v = 11'd250;
      4'h7: v = 11'd310;
      4'h8: v = 11'd350;
      4'h9: v = 11'd400;
      4'hA: v = 11'd440;
      4'hB: v = 11'd500;
      4'hC: v = 11'd580;
      4'hD: v = 11'd700;
      4'hE: v = 11'd900;
      4'hF: v = 11'd1100;
    endcase
    return v;
  endfunction : gdc_src_ma
endpackage : gdc_pkg

// *** verilog/gdc_cal_seq.sv ***
/*
  One offset calibration sequencer: a start pulse runs a timed calibration,
  busy stays high until done or abort. Assumes one clock and synchronous reset.
*/
`timescale 1ns/1ps
module gdc_cal_seq #(
  parameter int CYCLES = gdc_pkg::CAL_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  import gdc_pkg::*;
  if (CYCLES < 1) begin : g_bad_cycles
    $error("CYCLES must be at least one");
  end
  gdc_cal_t    state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      GDC_IDLE: if (start) begin
        state_d = GDC_RUN;
        cnt_d   = 32'(CYCLES - 1);
      end
      GDC_RUN: if (cnt_q == 32'h0000_0000) state_d = GDC_DONE;
               else cnt_d = cnt_q - 32'h0000_0001;
      GDC_DONE: if (start) begin
        state_d = GDC_RUN;
        cnt_d   = 32'(CYCLES - 1);
      end else begin
        state_d = GDC_IDLE;
      end
      default: state_d = GDC_IDLE;
    endcase
    if (abort) state_d = GDC_IDLE;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= GDC_IDLE;
      cnt_q   <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end
  assign busy = (state_q == GDC_RUN);
  assign done = (state_q == GDC_DONE);
endmodule : gdc_cal_seq

// *** verilog/gdc_src_decode.sv ***
/*
  Drive current decode: source and doubled sink current for one driver side.
  Assumes the code comes from a register.
*/
`timescale 1ns/1ps
module gdc_src_decode (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Code in, currents out
  input  wire logic [3:0]  code,
  output logic      [10:0] srcMa,
  output logic      [11:0] sinkMa
);
  import gdc_pkg::*;
  logic [10:0] src_d;
  always_comb src_d = gdc_src_ma(code);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srcMa  <= 11'h000;
      sinkMa <= 12'h000;
    end else begin
      srcMa  <= src_d;
      sinkMa <= {src_d, 1'b0};
    end
  end
endmodule : gdc_src_decode

// *** testbench/gdc_host_model.sv ***
/*
  Host side model: issues one-cycle register writes and reads.
  Assumes the bank takes a strobe on the rising clock edge.
*/
`timescale 1ns/1ps
module gdc_host_model (
  // Clock
  input  wire logic        clk,
  // Register access port
  output logic             regWrite,
  output logic             regRead,
  output logic      [3:0]  regIndex,
  output logic      [11:0] regWdata,
  input  wire logic [11:0] regRdata,
  input  wire logic        regHit
);
  initial begin
    regWrite = 1'b0;
    regRead  = 1'b0;
    regIndex = 4'h0;
    regWdata = 12'h0_000;
  end

  task automatic wr(input logic [3:0] i, input logic [11:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regIndex <= i;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    regWdata <= ~d;
  endtask : wr

  task automatic rd(input logic [3:0] i, output logic [11:0] q, output logic h);
    @(posedge clk);
    regRead  <= 1'b1;
    regIndex <= i;
    @(posedge clk);
    regRead  <= 1'b0;
    #1;
    q = regRdata;
    h = regHit;
  endtask : rd
endmodule : gdc_host_model

// *** testbench/gdc_config_regs_assertions.sv ***
/*
  Checker for the configuration bank, bound to its top module.
  Assumes one clock and synchronous active high reset.
*/
`timescale 1ns/1ps
module gdc_config_regs_assertions #(
  parameter int CAL_CYCLES = gdc_pkg::CAL_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        sleepEnter,
  input  wire logic        calInputConnect,
  // Settings
  input  wire logic [9:0]  overcurrentThreshMv,
  input  wire logic [5:0]  senseGain,
  input  wire logic        emfSenseEnable,
  input  wire logic        ampCForEmf,
  input  wire logic [12:0] gateTransitionNs,
  input  wire logic [10:0] hsSourceMa,
  input  wire logic [11:0] hsSinkMa,
  input  wire logic [10:0] lsSourceMa,
  input  wire logic [11:0] lsSinkMa,
  // Calibration
  input  wire logic        calRunA,
  input  wire logic        calRunB,
  input  wire logic        calRunC,
  input  wire logic        calRunEmf,
  input  wire logic        calShortInputs
);
  logic anyRun;
  assign anyRun = calRunA | calRunB | calRunC | calRunEmf;
  // Length of the current run of A and B
  logic [31:0] runLenA, runLenB;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      runLenA <= 32'h0000_0000;
      runLenB <= 32'h0000_0000;
    end else begin
      runLenA <= calRunA ? runLenA + 32'h0000_0001 : 32'h0000_0000;
      runLenB <= calRunB ? runLenB + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_hs_sink_double: assert property (hsSinkMa == {hsSourceMa, 1'b0})
    else $error("high side sink not twice source");
  a_ls_sink_double: assert property (lsSinkMa == {lsSourceMa, 1'b0})
    else $error("low side sink not twice source");
  a_cal_a_ends: assert property (calRunA |-> runLenA < 32'(CAL_CYCLES))
    else $error("amp A calibration does not end");
  a_cal_b_ends: assert property ($fell(calRunB) && !$past(sleepEnter, 2) && !$past(sys_rst)
    |-> runLenB == 32'(CAL_CYCLES))
    else $error("amp B calibration length wrong");
  a_c_emf_exclusive: assert property ($rose(calRunC) |-> !calRunEmf && !emfSenseEnable)
    else $error("amp C calibrated with emf enabled");
  a_emf_cal_mode: assert property ($rose(calRunEmf) |-> !calRunC && emfSenseEnable)
    else $error("emf calibration with emf disabled");
  a_amp_c_follows: assert property (ampCForEmf == emfSenseEnable)
    else $error("amp C use differs from emf enable");
  a_short_inputs: assert property ($past(anyRun) && anyRun && $stable(calInputConnect)
    |-> calShortInputs == !calInputConnect)
    else $error("input short wrong during calibration");
  a_sleep_defaults: assert property (sleepEnter [*2] |=> overcurrentThreshMv == 10'd500
    && gateTransitionNs == 13'd1000 && lsSourceMa == 11'd1100)
    else $error("sleep did not restore defaults");
  a_sleep_abort: assert property (sleepEnter |-> ##2 !(calRunA || calRunB))
    else $error("sleep did not stop calibration");
  a_reset_defaults: assert property ($fell(sys_rst) |-> ##2 senseGain == 6'd20
    && hsSinkMa == 12'd2200)
    else $error("defaults missing after reset");
endmodule : gdc_config_regs_assertions

bind gdc_config_regs gdc_config_regs_assertions #(.CAL_CYCLES(CAL_CYCLES)) chk (.*);

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the configuration bank with a host model.
  Assumes 250 MHz clock and synchronous reset held 20 cycles.
*/
`timescale 1ns/1ps
module tb_top;
  import gdc_pkg::*;
  localparam int CYC = 8;
  logic        clk = 0, sys_rst = 1, sleepEnter = 0, calInputConnect = 0;
  logic        regWrite, regRead, regHit, emfSenseEnable, ampCForEmf, commonPinSel;
  logic        calRunA, calRunB, calRunC, calRunEmf, calShortInputs;
  logic [3:0]  regIndex;
  logic [11:0] regWdata, regRdata, hsSinkMa, lsSinkMa;
  logic [9:0]  overcurrentThreshMv;
  logic [5:0]  senseGain;
  logic [3:0]  emfGainQuarters;
  logic [12:0] gateTransitionNs;
  logic [10:0] hsSourceMa, lsSourceMa;
  int          n_fail = 0, cmp_count = 0;
  int          thTab[8] = '{50, 100, 150, 200, 250, 500, 750, 1000};
  int          srcTab[16] = '{50, 70, 120, 160, 200, 220, 250, 310, 350, 400, 440, 500, 580, 700, 900, 1100};

  always #2 clk = ~clk;
  gdc_config_regs #(.CAL_CYCLES(CYC)) dut (.*);
  gdc_host_model host (.*);

  function automatic logic [12:0] exp_src(input logic [3:0] c);
    return 13'(srcTab[c]);
  endfunction : exp_src

  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial begin
    logic [11:0] s, d, q;
    logic        h;
    int          r;
    r = $urandom(32'h279a);
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    host.rd(4'h4, q, h);
    check("sense reset", q, 12'h0_B02);
    check("sense hit", h, 1'b1);
    check("gain reset", senseGain, 13'd20);
    check("threshold reset", overcurrentThreshMv, 13'd500);
    host.rd(4'h5, q, h);
    check("drive reset", q, 12'h0_7FC);
    check("transition reset", gateTransitionNs, 13'd1000);
    host.rd(4'h7, q, h);
    check("unmapped data", q, 12'h0_000);
    check("unmapped hit", h, 1'b0);
    for (int i = 0; i < 16; i++) begin
      r = $urandom;
      s = {i[2:0], i[1:0], 3'b000, r[0], r[2:1], r[3]};
      d = {i[1:0], i[3:0], ~i[3:0], r[5:4]};
      host.wr(4'h4, s);
      host.wr(4'h5, d);
      host.rd(4'h4, q, h);
      check("sense read", q, s);
      host.rd(4'h5, q, h);
      check("drive read", q, d & 12'h0_FFC);
      check("threshold", overcurrentThreshMv, 13'(thTab[s[11:9]]));
      check("sense gain", senseGain, 13'd5 << s[8:7]);
      check("emf enable", emfSenseEnable, s[3]);
      check("amp C use", ampCForEmf, s[3]);
      check("emf gain", emfGainQuarters, 13'd1 << s[2:1]);
      check("common select", commonPinSel, s[0]);
      check("transition", gateTransitionNs, 13'd500 << d[11:10]);
      check("hs source", hsSourceMa, exp_src(d[9:6]));
      check("ls source", lsSourceMa, exp_src(d[5:2]));
      check("hs sink", hsSinkMa, exp_src(d[9:6]) << 1);
      check("ls sink", lsSinkMa, exp_src(d[5:2]) << 1);
    end
    host.wr(4'h9, 12'h0_FFF);
    host.rd(4'h4, q, h);
    check("unmapped write", q, s);
    host.wr(4'h4, 12'h0_A72);
    host.rd(4'h4, q, h);
    check("triggers running", q, 12'h0_A72);
    check("run A", calRunA, 1'b1);
    check("run B", calRunB, 1'b1);
    check("run C", calRunC, 1'b1);
    check("run emf off", calRunEmf, 1'b0);
    check("short inputs", calShortInputs, 1'b1);
    repeat (CYC + 6) @(posedge clk);
    host.rd(4'h4, q, h);
    check("triggers cleared", q, 12'h0_A02);
    @(posedge clk);
    calInputConnect <= 1'b1;
    host.wr(4'h4, 12'h0_A1A);
    host.rd(4'h4, q, h);
    check("emf trigger", q, 12'h0_A1A);
    check("run emf", calRunEmf, 1'b1);
    check("run C off", calRunC, 1'b0);
    check("keep shunt", calShortInputs, 1'b0);
    host.wr(4'h4, 12'h0_A0A);
    @(posedge clk);
    #1;
    check("zero write", calRunEmf, 1'b1);
    host.wr(4'h4, 12'h0_A42);
    @(posedge clk);
    sleepEnter <= 1'b1;
    repeat (2) @(posedge clk);
    sleepEnter <= 1'b0;
    host.rd(4'h4, q, h);
    check("sleep sense", q, 12'h0_B02);
    check("sleep run A", calRunA, 1'b0);
    host.rd(4'h5, q, h);
    check("sleep drive", q, 12'h0_7FC);
    final_report();
  end
endmodule : tb_top
